// ---- pkg/dpram_port_pkg.sv ----
package dpram_port_pkg;

  localparam int ADDR_W    = 13;
  localparam int DATA_W    = 18;
  localparam int WORDS     = 8192;
  localparam logic [12:0] CNT_CLEAR_VAL = 13'h0000;
  localparam logic [12:0] CNT_STEP      = 13'h0001;

  // Sampled per-cycle control from the master
  typedef struct packed {
    logic selectLowActive_n;
    logic selectHighActive;
    logic readNotWrite;
    logic loadStrobe_n;
    logic countAdvance_n;
    logic counterClear_n;
  } port_ctrl_s;

  typedef enum logic [1:0] {
    OP_IDLE,
    OP_WRITE,
    OP_READ
  } port_op_e;

endpackage

// ---- rtl/port_ram_mem.sv ----
`timescale 1ns/10ps
module port_ram_mem #(
  parameter int ADDR_W = 13,
  parameter int DATA_W = 18,
  parameter int WORDS  = 8192
) (
  // Clock
  input  wire logic              sys_clk,
  // Access
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic              wrEn,
  input  wire logic [DATA_W-1:0] wrData,
  output logic      [DATA_W-1:0] rdData
);

  logic [DATA_W-1:0] store [WORDS];
  logic [DATA_W-1:0] rdData_r;

  // Read-before-write; no reset on the array itself
  always_ff @(posedge sys_clk) begin
    if (wrEn) begin
      store[addr] <= wrData;
    end
    rdData_r <= store[addr];
  end

  assign rdData = rdData_r;

endmodule // port_ram_mem

// ---- rtl/sync_dpram_port.sv ----
`timescale 1ns/10ps
module sync_dpram_port #(
  parameter int ADDR_W = dpram_port_pkg::ADDR_W,
  parameter int DATA_W = dpram_port_pkg::DATA_W,
  parameter int WORDS  = dpram_port_pkg::WORDS
) (
  // Clock and reset
  input  wire logic                        sys_clk,
  input  wire logic                        rst_b,
  // Mode strap, high selects pipelined
  input  wire logic                        output_register_select,
  // Synchronous control
  input  wire dpram_port_pkg::port_ctrl_s  ctrl,
  input  wire logic [ADDR_W-1:0]           extAddr,
  // Asynchronous output enable, active low
  input  wire logic                        outEnable_n,
  // Data pins
  input  wire logic [DATA_W-1:0]           dataIn,
  output logic      [DATA_W-1:0]           dataOut,
  output logic                             dataOe_n,
  // Current array address, for observation
  output logic      [ADDR_W-1:0]           arrayAddr
);

  logic [ADDR_W-1:0]      counter_r;
  logic [ADDR_W-1:0]      counter_nxt;
  dpram_port_pkg::port_op_e opFlow;
  dpram_port_pkg::port_op_e opFlow_r;
  dpram_port_pkg::port_op_e opFlow_nxt;
  dpram_port_pkg::port_op_e opPipe_r;
  dpram_port_pkg::port_op_e opPipe_nxt;
  logic [DATA_W-1:0]      pipeData_r;
  logic [DATA_W-1:0]      pipeData_nxt;
  logic [DATA_W-1:0]      memRd;
  logic                   selected;
  logic                   driveEn;

  // Selected only when both selects active
  assign selected = !ctrl.selectLowActive_n && ctrl.selectHighActive;

  // Load costs no cycle: access uses the address presented now
  always_comb begin
    if (!ctrl.loadStrobe_n) begin
      arrayAddr = extAddr;
    end else begin
      arrayAddr = counter_r;
    end
  end

  // Selects do not enter the counter logic
  always_comb begin
    if (!ctrl.counterClear_n) begin
      counter_nxt = ADDR_W'(dpram_port_pkg::CNT_CLEAR_VAL);
    end else if (!ctrl.loadStrobe_n) begin
      counter_nxt = extAddr;
    end else if (!ctrl.countAdvance_n) begin
      counter_nxt = counter_r + ADDR_W'(dpram_port_pkg::CNT_STEP);
    end else begin
      counter_nxt = counter_r;
    end
  end

  always_comb begin
    if (!selected) begin
      opFlow = dpram_port_pkg::OP_IDLE;
    end else if (!ctrl.readNotWrite) begin
      opFlow = dpram_port_pkg::OP_WRITE;
    end else begin
      opFlow = dpram_port_pkg::OP_READ;
    end
  end

  port_ram_mem #(
    .ADDR_W (ADDR_W),
    .DATA_W (DATA_W),
    .WORDS  (WORDS)
  ) port_ram_mem_inst (
    .sys_clk (sys_clk),
    .addr    (arrayAddr),
    .wrEn    (opFlow == dpram_port_pkg::OP_WRITE),
    .wrData  (dataIn),
    .rdData  (memRd)
  );

  // Pipeline stage: output register one cycle behind flow-through
  always_comb begin
    opFlow_nxt   = opFlow;
    opPipe_nxt   = opFlow_r;
    pipeData_nxt = memRd;
  end

  // Only edge-sampled state; output enable never enters here
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      counter_r  <= '0;
      opFlow_r   <= dpram_port_pkg::OP_IDLE;
      opPipe_r   <= dpram_port_pkg::OP_IDLE;
      pipeData_r <= '0;
    end else begin
      counter_r  <= counter_nxt;
      opFlow_r   <= opFlow_nxt;
      opPipe_r   <= opPipe_nxt;
      pipeData_r <= pipeData_nxt;
    end
  end

  // Output enable gates combinationally, no clock involved
  always_comb begin
    if (output_register_select) begin
      driveEn = (opPipe_r == dpram_port_pkg::OP_READ);
      dataOut = pipeData_r;
    end else begin
      driveEn = (opFlow_r == dpram_port_pkg::OP_READ);
      dataOut = memRd;
    end
    dataOe_n = !(driveEn && !outEnable_n);
  end

  a_clear_zero: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !ctrl.counterClear_n |=> counter_r == '0)
    else $error("Counter not zero after clear");

  a_load_ext: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ctrl.counterClear_n && !ctrl.loadStrobe_n |=> counter_r == $past(extAddr))
    else $error("Counter did not load external address");

  a_hold_cnt: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ctrl.counterClear_n && ctrl.loadStrobe_n && ctrl.countAdvance_n |=> $stable(counter_r))
    else $error("Counter moved during hold");

  a_incr_cnt: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ctrl.counterClear_n && ctrl.loadStrobe_n && !ctrl.countAdvance_n
      |=> counter_r == ADDR_W'($past(counter_r) + 1'b1))
    else $error("Counter did not step by one");

  a_addr_mux: assert property (@(posedge sys_clk) disable iff (!rst_b)
    arrayAddr == (ctrl.loadStrobe_n ? counter_r : extAddr))
    else $error("Array address source wrong");

  a_oe_tristate: assert property (@(posedge sys_clk) disable iff (!rst_b)
    outEnable_n |-> dataOe_n)
    else $error("Driving with output enable high");

  a_pipe_deselect: assert property (@(posedge sys_clk) disable iff (!rst_b)
    output_register_select && !selected ##1 output_register_select |=> dataOe_n)
    else $error("Pipelined deselect not two edges later");

  a_pipe_read: assert property (@(posedge sys_clk) disable iff (!rst_b)
    output_register_select && selected && ctrl.readNotWrite ##1 output_register_select
      |=> (dataOe_n == outEnable_n))
    else $error("Pipelined read did not drive");

  a_flow_read: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !output_register_select && selected && ctrl.readNotWrite ##1 !output_register_select
      |-> (dataOe_n == outEnable_n))
    else $error("Flow-through read did not drive");

  a_pipe_data: assert property (@(posedge sys_clk) disable iff (!rst_b)
    output_register_select && opFlow_r == dpram_port_pkg::OP_READ
      |=> dataOut == $past(memRd))
    else $error("Pipelined data not one cycle behind");

  a_flow_deselect: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !output_register_select && !selected ##1 !output_register_select
      |-> dataOe_n)
    else $error("Flow-through deselect still driving");

  a_flow_write_quiet: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !output_register_select && selected && !ctrl.readNotWrite ##1 !output_register_select
      |-> dataOe_n)
    else $error("Flow-through write cycle driving");

  a_pipe_write_quiet: assert property (@(posedge sys_clk) disable iff (!rst_b)
    output_register_select && selected && !ctrl.readNotWrite ##1 output_register_select
      |=> dataOe_n)
    else $error("Pipelined write cycle driving");

  a_clear_access: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !ctrl.counterClear_n && ctrl.loadStrobe_n
      |-> arrayAddr == counter_r)
    else $error("Clear cycle did not access current counter");

  a_reset_quiet: assert property (@(posedge sys_clk)
    !rst_b
      |=> dataOe_n)
    else $error("Driving after a reset edge");

  a_hold_addr: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ctrl.counterClear_n && ctrl.loadStrobe_n && ctrl.countAdvance_n
      |-> arrayAddr == counter_r)
    else $error("Hold cycle used external address");

  a_clear_over_load: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !ctrl.counterClear_n && !ctrl.loadStrobe_n
      |=> counter_r == '0)
    else $error("Load won over clear");

  a_wrap_top: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ctrl.counterClear_n && ctrl.loadStrobe_n && !ctrl.countAdvance_n && counter_r == '1
      |=> counter_r == '0)
    else $error("Counter did not wrap to zero");

  a_count_deselected: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !selected && ctrl.counterClear_n && ctrl.loadStrobe_n && !ctrl.countAdvance_n
      |=> counter_r == ADDR_W'($past(counter_r) + 1'b1))
    else $error("Counter stalled while deselected");

endmodule // sync_dpram_port

// ---- verification/port_master.sv ----
`timescale 1ns/10ps
module port_master (
  // Clock
  input  wire logic                          sys_clk,
  // Port pins driven by the master
  output dpram_port_pkg::port_ctrl_s         ctrl,
  output logic [dpram_port_pkg::ADDR_W-1:0]  extAddr,
  output logic [dpram_port_pkg::DATA_W-1:0]  dataIn,
  output logic                               outEnable_n
);
  logic lowSelect_n;
  initial begin
    lowSelect_n = 1'b0;
    ctrl = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
    extAddr = '0;
    dataIn = '0;
    outEnable_n = 1'b0;
  end
  // Falling edge keeps changes clear of sampling; no no-op cycles are issued
  task automatic drive(input logic sel, rnw, ld, adv, clr, input logic [12:0] a, input logic [17:0] d);
    @(negedge sys_clk);
    ctrl = '{lowSelect_n, sel, rnw, ld, adv, clr};
    extAddr = a;
    dataIn = rnw ? ~dataIn : d; // Unused data keeps moving
  endtask
  task automatic setOe(input logic v);
    outEnable_n = v;
  endtask
  // Takes effect at the next drive's falling edge
  task automatic setLowSel(input logic v);
    lowSelect_n = v;
  endtask
endmodule // port_master

// ---- verification/sync_dpram_port_tb.sv ----
`timescale 1ns/10ps
module sync_dpram_port_tb;
  logic                       sys_clk = 1'b0;
  logic                       rst_b = 1'b0;
  logic                       pipeMode = 1'b1;
  int                         failures = 0;
  int                         cmp_count = 0;
  int                         cycles = 0;
  dpram_port_pkg::port_ctrl_s ctrl;
  logic [12:0]                extAddr;
  logic [12:0]                arrayAddr;
  logic [17:0]                dataIn;
  logic [17:0]                dataOut;
  logic                       outEnable_n;
  logic                       dataOe_n;
  always #5 sys_clk = ~sys_clk;
  port_master port_master_inst (.sys_clk(sys_clk), .ctrl(ctrl), .extAddr(extAddr), .dataIn(dataIn),
    .outEnable_n(outEnable_n));
  sync_dpram_port sync_dpram_port_inst (.sys_clk(sys_clk), .rst_b(rst_b), .output_register_select(pipeMode),
    .ctrl(ctrl), .extAddr(extAddr), .outEnable_n(outEnable_n), .dataIn(dataIn), .dataOut(dataOut),
    .dataOe_n(dataOe_n), .arrayAddr(arrayAddr));
  task automatic check(input logic [17:0] seen, input logic [17:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic drv(input logic s, r, l, a, c, input logic [12:0] ad, input logic [17:0] d);
    port_master_inst.drive(s, r, l, a, c, ad, d);
  endtask
  task automatic doReset;
    rst_b = 1'b0;
    repeat (4) @(negedge sys_clk);
    rst_b = 1'b1;
  endtask
  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic tReadWrite;
    drv(1, 0, 0, 1, 1, 13'h0001, 18'h2aaaa);
    drv(1, 0, 0, 1, 1, 13'h0002, 18'h15555);
    drv(1, 1, 0, 1, 1, 13'h0001, 18'h00000);
    drv(1, 1, 0, 1, 1, 13'h0002, 18'h00000);
    check(18'(dataOe_n), 18'h00001);
    drv(0, 1, 0, 1, 1, 13'h0000, 18'h00000);
    check(dataOut, 18'h2aaaa);
    check(18'(dataOe_n), 18'h00000);
    drv(0, 1, 0, 1, 1, 13'h0000, 18'h00000);
    check(dataOut, 18'h15555);
    port_master_inst.setOe(1'b1);
    #1 check(18'(dataOe_n), 18'h00001);
    port_master_inst.setOe(1'b0);
    drv(0, 1, 0, 1, 1, 13'h0000, 18'h00000);
    check(18'(dataOe_n), 18'h00001);
  endtask
  task automatic tCounter;
    drv(0, 1, 0, 1, 1, 13'h1fff, 18'h00000);
    #1 check({5'h00, arrayAddr}, 18'h01fff);
    drv(0, 1, 1, 1, 1, 13'h0005, 18'h00000);
    #1 check({5'h00, arrayAddr}, 18'h01fff);
    drv(0, 1, 1, 0, 1, 13'h0005, 18'h00000);
    #1 check({5'h00, arrayAddr}, 18'h01fff);
    drv(0, 1, 1, 0, 1, 13'h0005, 18'h00000);
    #1 check({5'h00, arrayAddr}, 18'h00000);
    drv(1, 1, 1, 1, 0, 13'h0005, 18'h00000);
    #1 check({5'h00, arrayAddr}, 18'h00001);
    drv(0, 1, 1, 1, 1, 13'h0005, 18'h00000);
    #1 check({5'h00, arrayAddr}, 18'h00000);
    drv(0, 1, 1, 1, 1, 13'h0005, 18'h00000);
    check(dataOut, 18'h2aaaa);
    drv(0, 1, 0, 1, 0, 13'h0005, 18'h00000);
    #1 check({5'h00, arrayAddr}, 18'h00005);
    drv(0, 1, 1, 1, 1, 13'h0005, 18'h00000);
    #1 check({5'h00, arrayAddr}, 18'h00000);
  endtask
  task automatic tFlow;
    drv(1, 0, 0, 1, 1, 13'h0007, 18'h0abcd);
    drv(1, 1, 0, 1, 1, 13'h0007, 18'h00000);
    drv(0, 1, 0, 1, 1, 13'h0000, 18'h00000);
    check(dataOut, 18'h0abcd);
    check(18'(dataOe_n), 18'h00000);
    drv(0, 1, 0, 1, 1, 13'h0000, 18'h00000);
    check(18'(dataOe_n), 18'h00001);
    port_master_inst.setLowSel(1'b1);
    drv(1, 0, 0, 1, 1, 13'h0007, 18'h3ffff);
    drv(1, 1, 0, 1, 1, 13'h0007, 18'h00000);
    port_master_inst.setLowSel(1'b0);
    drv(1, 1, 0, 1, 1, 13'h0007, 18'h00000);
    check(18'(dataOe_n), 18'h00001);
    drv(0, 1, 0, 1, 1, 13'h0000, 18'h00000);
    check(dataOut, 18'h0abcd);
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 500) begin
      failures++;
      stop_test();
    end
  end
  initial begin
    doReset();
    tReadWrite();
    tCounter();
    pipeMode = 1'b0;
    doReset();
    tFlow();
    stop_test();
  end
endmodule // sync_dpram_port_tb
